/* hw/gfx_mem_org_pkg.sv */
/*
 * Constants for the graphics memory organization block: register offsets,
 * configuration field positions, reset values and memory geometry.
 * Assumes offsets are byte offsets from the control block base.
 */
package gfx_mem_org_pkg;

    // Register block window
    localparam logic [15:0] BLOCK_BASE = 16'h8300;
    localparam logic [15:0] BLOCK_SPAN = 16'h0100;

    // Register offsets
    localparam logic [15:0] OFS_LOCK = 16'h8300;
    localparam logic [15:0] OFS_GENCFG = 16'h8304;
    localparam logic [15:0] OFS_TIMCFG = 16'h8308;
    localparam logic [15:0] OFS_OUTCFG = 16'h830C;
    localparam logic [15:0] OFS_FBSTART = 16'h8310;
    localparam logic [15:0] OFS_CBSTART = 16'h8314;
    localparam logic [15:0] OFS_CURSTART = 16'h8318;
    localparam logic [15:0] OFS_RSVD = 16'h831C;
    localparam logic [15:0] OFS_VIDSTART = 16'h8320;
    localparam logic [15:0] OFS_PITCH = 16'h8324;
    localparam logic [15:0] OFS_FETCH = 16'h8328;

    // Reset value of every register
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // general_configuration fields
    localparam int GEN_RES_LSB = 0;
    localparam int GEN_BPP16_BIT = 2;
    localparam int GEN_VGADIRECT_BIT = 3;

    // buffer_line_pitch fields (pitch in dwords)
    localparam int PITCH_FB_LSB = 0;
    localparam int PITCH_CB_LSB = 12;
    localparam int PITCH_W = 10;

    // line_fetch_size fields
    localparam int FETCH_FB_LSB = 0;
    localparam int FETCH_FB_W = 9;
    localparam int FETCH_CB_LSB = 9;
    localparam int FETCH_CB_W = 7;

    // Aperture geometry: 512 KB units, at most 4 MB
    localparam int UNIT_SHIFT = 19;
    localparam int UNIT_W = 13;
    localparam logic [3:0] MAX_UNITS = 4'h8;
    localparam int OFFSET_W = 22;
    localparam int VGA_SHIFT = 18;

    // Resolutions
    typedef enum logic [1:0] {
        RES_640 = 2'b00,
        RES_800 = 2'b01,
        RES_1024 = 2'b10,
        RES_1280 = 2'b11
    } res_type;

endpackage

/* hw/gfx_mem_org.sv */
/*
 * Graphics memory organization: aperture decode, XY frame buffer and
 * compressed buffer addressing, pixel lane packing, and the memory
 * organization register bank with its write lock.
 * Assumes a single core clock and host register strobes synchronous to it.
 */
`timescale 1ns/1ns

// Summary of operation
// - Aperture at most 4 MB above RAM
// - Aperture starts at top of RAM
// - Aperture placed in 512 KB steps
// - Memory addressed by word offset, byte enables
// - Pixel offset is Y concatenated with X
// - Four resolutions; 1280 only at 8 bpp
// - 8 bpp lines below 1280 1024 bytes apart
// - 16 bpp and 1280 lines 2048 apart
// - Compressed line sits in line gap
// - 1024 modes: compressed buffer linear after frame
// - Pixels packed little-endian into dwords
// - VGA data in own 256 KB region
// - Direct refresh from VGA memory
// - Registers at base plus 8300h, 100h long
// - Lock blocks critical writes; reads always work
// - Start offsets for four buffers
// - Pitch register for frame and compressed
// - Oversized compressed line clears cbLineOk
module gfx_mem_org (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic regSel,
    input wire logic regWrite,
    input wire logic [15:0] regAddr,
    input wire logic [3:0] regByteEn,
    input wire logic [31:0] regWdata,
    output logic [31:0] regRdata,
    output logic regAck,
    // Aperture placement
    input wire logic [12:0] ramTopUnits,
    input wire logic [3:0] apertureUnits,
    input wire logic [3:0] vgaRegionSel,
    // Host access into the aperture
    input wire logic hostValid,
    input wire logic [31:0] hostAddr,
    input wire logic [3:0] hostByteEn,
    output logic apHit,
    output logic [19:0] apWordOffset,
    output logic [3:0] apByteEn,
    // Pixel request
    input wire logic pixValid,
    input wire logic [10:0] pixX,
    input wire logic [9:0] pixY,
    input wire logic [15:0] pixData,
    output logic pixOutValid,
    output logic [19:0] pixWordOffset,
    output logic [3:0] pixByteEn,
    output logic [31:0] pixWdata,
    // Compressed line request
    input wire logic cbReq,
    input wire logic [9:0] cbLine,
    input wire logic [6:0] cbLineLen,
    output logic cbOutValid,
    output logic [19:0] cbWordOffset,
    output logic cbLineOk,
    // Buffer locations and status
    output logic [19:0] cursorWordOffset,
    output logic [19:0] videoWordOffset,
    output logic [8:0] fbFetchSize,
    output logic modeIllegal,
    output logic writeLocked
);

    ////////////////////////////////////////////////////////////////////////////
    // Register bank
    logic [31:0] lock_r;
    logic [31:0] genCfg_r;
    logic [31:0] timCfg_r;
    logic [31:0] outCfg_r;
    logic [31:0] fbStart_r;
    logic [31:0] cbStart_r;
    logic [31:0] curStart_r;
    logic [31:0] vidStart_r;
    logic [31:0] pitch_r;
    logic [31:0] fetch_r;
    logic inBlock;
    logic [15:0] wordAddr;
    logic wrEn;
    logic wrCritical;

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Byte offset inside the aperture window
    function automatic logic [21:0] apOffset(input logic [31:0] addr, input logic [12:0] baseUnits);
        logic [31:0] diff;
        diff = addr - {baseUnits, 19'h0};
        return diff[gfx_mem_org_pkg::OFFSET_W-1:0];
    endfunction

    assign inBlock = (regAddr >= gfx_mem_org_pkg::BLOCK_BASE)
                  && (regAddr < gfx_mem_org_pkg::BLOCK_BASE + gfx_mem_org_pkg::BLOCK_SPAN);
    assign wordAddr = {regAddr[15:2], 2'b00};
    assign wrEn = regSel && regWrite && inBlock;
    assign writeLocked = (lock_r != 32'h0000_0000);
    assign wrCritical = wrEn && !writeLocked;

    // Lock register itself stays writable
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lock_r <= gfx_mem_org_pkg::REG_RESET;
        end
        else if (wrEn && wordAddr == gfx_mem_org_pkg::OFS_LOCK)
        begin
            lock_r <= merge(lock_r, regWdata, regByteEn);
        end
    end

    // Guarded registers; locked writes leave no trace
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            genCfg_r <= gfx_mem_org_pkg::REG_RESET;
            timCfg_r <= gfx_mem_org_pkg::REG_RESET;
            outCfg_r <= gfx_mem_org_pkg::REG_RESET;
            fbStart_r <= gfx_mem_org_pkg::REG_RESET;
            cbStart_r <= gfx_mem_org_pkg::REG_RESET;
            curStart_r <= gfx_mem_org_pkg::REG_RESET;
            vidStart_r <= gfx_mem_org_pkg::REG_RESET;
            pitch_r <= gfx_mem_org_pkg::REG_RESET;
            fetch_r <= gfx_mem_org_pkg::REG_RESET;
        end
        else if (wrCritical)
        begin
            unique case (wordAddr)
                gfx_mem_org_pkg::OFS_GENCFG: genCfg_r <= merge(genCfg_r, regWdata, regByteEn);
                gfx_mem_org_pkg::OFS_TIMCFG: timCfg_r <= merge(timCfg_r, regWdata, regByteEn);
                gfx_mem_org_pkg::OFS_OUTCFG: outCfg_r <= merge(outCfg_r, regWdata, regByteEn);
                gfx_mem_org_pkg::OFS_FBSTART: fbStart_r <= merge(fbStart_r, regWdata, regByteEn);
                gfx_mem_org_pkg::OFS_CBSTART: cbStart_r <= merge(cbStart_r, regWdata, regByteEn);
                gfx_mem_org_pkg::OFS_CURSTART: curStart_r <= merge(curStart_r, regWdata, regByteEn);
                gfx_mem_org_pkg::OFS_VIDSTART: vidStart_r <= merge(vidStart_r, regWdata, regByteEn);
                gfx_mem_org_pkg::OFS_PITCH: pitch_r <= merge(pitch_r, regWdata, regByteEn);
                gfx_mem_org_pkg::OFS_FETCH: fetch_r <= merge(fetch_r, regWdata, regByteEn);
                default: ;
            endcase
        end
    end

    // Read path, one cycle after the strobe; reads ignore the lock
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            regRdata <= 32'h0000_0000;
            regAck <= 1'b0;
        end
        else
        begin
            regAck <= regSel && inBlock;
            if (regSel && !regWrite && inBlock)
            begin
                unique case (wordAddr)
                    gfx_mem_org_pkg::OFS_LOCK: regRdata <= lock_r;
                    gfx_mem_org_pkg::OFS_GENCFG: regRdata <= genCfg_r;
                    gfx_mem_org_pkg::OFS_TIMCFG: regRdata <= timCfg_r;
                    gfx_mem_org_pkg::OFS_OUTCFG: regRdata <= outCfg_r;
                    gfx_mem_org_pkg::OFS_FBSTART: regRdata <= fbStart_r;
                    gfx_mem_org_pkg::OFS_CBSTART: regRdata <= cbStart_r;
                    gfx_mem_org_pkg::OFS_CURSTART: regRdata <= curStart_r;
                    gfx_mem_org_pkg::OFS_VIDSTART: regRdata <= vidStart_r;
                    gfx_mem_org_pkg::OFS_PITCH: regRdata <= pitch_r;
                    gfx_mem_org_pkg::OFS_FETCH: regRdata <= fetch_r;
                    default: regRdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode
    gfx_mem_org_pkg::res_type res;
    logic bpp16;
    logic wideDelta;
    logic gapMode;
    logic vgaDirect;

    assign res = gfx_mem_org_pkg::res_type'(genCfg_r[gfx_mem_org_pkg::GEN_RES_LSB +: 2]);
    // 1280 has no 16 bpp form; it is run as 8 bpp and flagged
    assign modeIllegal = (res == gfx_mem_org_pkg::RES_1280) && genCfg_r[gfx_mem_org_pkg::GEN_BPP16_BIT];
    assign bpp16 = genCfg_r[gfx_mem_org_pkg::GEN_BPP16_BIT] && !modeIllegal;
    assign wideDelta = bpp16 || (res == gfx_mem_org_pkg::RES_1280);
    assign gapMode = (res != gfx_mem_org_pkg::RES_1024);
    assign vgaDirect = genCfg_r[gfx_mem_org_pkg::GEN_VGADIRECT_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Aperture decode
    logic [3:0] apUnits;
    logic [13:0] apEndUnits;
    logic apInside;
    logic [21:0] apByteOfs;

    assign apUnits = (apertureUnits > gfx_mem_org_pkg::MAX_UNITS) ? gfx_mem_org_pkg::MAX_UNITS
                                                                  : apertureUnits;
    assign apEndUnits = {1'b0, ramTopUnits} + {10'h000, apUnits};
    assign apInside = ({1'b0, hostAddr[31:gfx_mem_org_pkg::UNIT_SHIFT]} >= {1'b0, ramTopUnits})
                   && ({1'b0, hostAddr[31:gfx_mem_org_pkg::UNIT_SHIFT]} < apEndUnits);
    assign apByteOfs = apOffset(hostAddr, ramTopUnits);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            apHit <= 1'b0;
            apWordOffset <= 20'h0_0000;
            apByteEn <= 4'h0;
        end
        else
        begin
            apHit <= hostValid && apInside;
            apWordOffset <= apByteOfs[21:2];
            apByteEn <= hostValid && apInside ? hostByteEn : 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame buffer addressing
    logic [11:0] xBytes;
    logic [21:0] xyOfs;
    logic [21:0] fbBase;
    logic [21:0] pixByteAddr;
    logic [21:0] vgaBase;

    assign xBytes = bpp16 ? {pixX, 1'b0} : {1'b0, pixX};
    // Line index and byte column concatenated, no multiply
    assign xyOfs = wideDelta ? {1'b0, pixY, xBytes[10:0]} : {2'b00, pixY, xBytes[9:0]};
    assign vgaBase = {vgaRegionSel, 18'h0_0000};
    assign fbBase = vgaDirect ? vgaBase : fbStart_r[21:0];
    // VGA refresh wraps within its 256 KB region
    assign pixByteAddr = vgaDirect ? (vgaBase | {4'h0, xyOfs[gfx_mem_org_pkg::VGA_SHIFT-1:0]})
                                   : (fbBase + xyOfs);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pixOutValid <= 1'b0;
            pixWordOffset <= 20'h0_0000;
            pixByteEn <= 4'h0;
            pixWdata <= 32'h0000_0000;
        end
        else
        begin
            pixOutValid <= pixValid;
            pixWordOffset <= pixByteAddr[21:2];
            if (bpp16)
            begin
                pixByteEn <= pixX[0] ? 4'hC : 4'h3;
                pixWdata <= {pixData, pixData};
            end
            else
            begin
                pixByteEn <= 4'h1 << pixX[1:0];
                pixWdata <= {4{pixData[7:0]}};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compressed buffer addressing
    logic [9:0] cbPitch;
    logic [6:0] cbLimit;
    logic [21:0] cbGapOfs;
    logic [21:0] cbLinOfs;
    logic [19:0] linProduct;

    assign cbPitch = pitch_r[gfx_mem_org_pkg::PITCH_CB_LSB +: gfx_mem_org_pkg::PITCH_W];
    assign cbLimit = fetch_r[gfx_mem_org_pkg::FETCH_CB_LSB +: gfx_mem_org_pkg::FETCH_CB_W];
    assign fbFetchSize = fetch_r[gfx_mem_org_pkg::FETCH_FB_LSB +: gfx_mem_org_pkg::FETCH_FB_W];
    // Start offset points into line 0's gap; later lines follow the line delta
    assign cbGapOfs = wideDelta ? {1'b0, cbLine, 11'h000} : {2'b00, cbLine, 10'h000};
    assign linProduct = cbLine * cbPitch;
    assign cbLinOfs = {linProduct, 2'b00};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cbOutValid <= 1'b0;
            cbWordOffset <= 20'h0_0000;
            cbLineOk <= 1'b0;
        end
        else
        begin
            cbOutValid <= cbReq;
            if (cbReq)
            begin
                cbWordOffset <= gapMode ? cbStart_r[21:2] + cbGapOfs[21:2]
                                        : cbStart_r[21:2] + cbLinOfs[21:2];
                cbLineOk <= (cbLineLen <= cbLimit);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cursor and video buffer locations
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cursorWordOffset <= 20'h0_0000;
            videoWordOffset <= 20'h0_0000;
        end
        else
        begin
            cursorWordOffset <= curStart_r[21:2];
            videoWordOffset <= vidStart_r[21:2];
        end
    end

endmodule

/* tb/gfx_mem_org_props.sv */
/*
 * Checker for the graphics memory organization block.
 * Assumes it sees only the block's ports, bound below.
 */
`timescale 1ns/1ns
module gfx_mem_org_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic regSel,
    input wire logic regWrite,
    input wire logic [15:0] regAddr,
    input wire logic [3:0] regByteEn,
    input wire logic [31:0] regWdata,
    input wire logic regAck,
    input wire logic writeLocked,
    // Aperture
    input wire logic [12:0] ramTopUnits,
    input wire logic [3:0] apertureUnits,
    input wire logic hostValid,
    input wire logic [31:0] hostAddr,
    input wire logic [3:0] hostByteEn,
    input wire logic apHit,
    input wire logic [19:0] apWordOffset,
    input wire logic [3:0] apByteEn,
    // Pixel and compressed paths
    input wire logic pixValid,
    input wire logic pixOutValid,
    input wire logic [31:0] pixWdata,
    input wire logic cbReq,
    input wire logic cbOutValid,
    input wire logic cbLineOk,
    input wire logic [19:0] cbWordOffset
);
logic [3:0] sizeUnits;
logic [13:0] apEnd;
logic hitNow;
logic [19:0] offNow;
logic lockWr;
logic inBlock;
assign sizeUnits = (apertureUnits > 4'h8) ? 4'h8 : apertureUnits;
assign apEnd = {1'b0, ramTopUnits} + {10'h0, sizeUnits};
assign hitNow = hostValid && (hostAddr[31:19] >= ramTopUnits) && ({1'b0, hostAddr[31:19]} < apEnd);
assign offNow = hostAddr[21:2] - {ramTopUnits[2:0], 17'h0};
assign lockWr = regSel && regWrite && (regAddr[15:2] == 14'h20C0) && (regByteEn == 4'hF);
assign inBlock = regSel && (regAddr[15:8] == 8'h83);
default clocking dc @(posedge clk);
endclocking
default disable iff (rst);
////////////////////////////////////////////////////////////////////////
property p_ack_in;
    inBlock |=> regAck;
endproperty
a_ack_in: assert property (p_ack_in) else $error("no ack for block access");
property p_ack_out;
    !inBlock |=> !regAck;
endproperty
a_ack_out: assert property (p_ack_out) else $error("stray ack");
property p_hit;
    hitNow |=> apHit && (apByteEn == $past(hostByteEn)) && (apWordOffset == $past(offNow));
endproperty
a_hit: assert property (p_hit) else $error("aperture hit wrong");
property p_miss;
    !hitNow |=> !apHit && (apByteEn == 4'h0);
endproperty
a_miss: assert property (p_miss) else $error("aperture miss wrong");
property p_lock_set;
    lockWr && (regWdata != 32'h0) |=> writeLocked;
endproperty
a_lock_set: assert property (p_lock_set) else $error("lock not set");
property p_lock_clr;
    lockWr && (regWdata == 32'h0) |=> !writeLocked;
endproperty
a_lock_clr: assert property (p_lock_clr) else $error("lock not cleared");
property p_pix;
    pixValid |=> pixOutValid && (pixWdata[31:16] == pixWdata[15:0]);
endproperty
a_pix: assert property (p_pix) else $error("pixel lanes wrong");
property p_cb_req;
    cbReq |=> cbOutValid;
endproperty
a_cb_req: assert property (p_cb_req) else $error("no compressed answer");
property p_cb_hold;
    !cbReq |=> !cbOutValid && $stable(cbLineOk) && $stable(cbWordOffset);
endproperty
a_cb_hold: assert property (p_cb_hold) else $error("compressed result moved");
endmodule
bind gfx_mem_org gfx_mem_org_props props (.clk, .rst, .regSel, .regWrite, .regAddr, .regByteEn, .regWdata,
    .regAck, .writeLocked, .ramTopUnits, .apertureUnits, .hostValid, .hostAddr, .hostByteEn, .apHit,
    .apWordOffset, .apByteEn, .pixValid, .pixOutValid, .pixWdata, .cbReq, .cbOutValid, .cbLineOk, .cbWordOffset);

/* tb/gfx_mem_model.sv */
/*
 * Graphics memory model: stores dword writes lane by lane.
 * Assumes write strobes synchronous to the core clock.
 */
`timescale 1ns/1ns
module gfx_mem_model (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic wrEn,
    input wire logic [19:0] wordOffset,
    input wire logic [3:0] byteEn,
    input wire logic [31:0] wdata
);
logic [31:0] mem [int];
function automatic logic [31:0] peek(input logic [19:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 32'h0;
endfunction
always_ff @(posedge clk)
begin
    for (int i = 0; i < 4; i++)
    begin
        if (wrEn && byteEn[i])
        begin
            mem[int'(wordOffset)][8*i +: 8] <= wdata[8*i +: 8];
        end
    end
end
endmodule

/* tb/gfx_mem_org_tb.sv */
/*
 * Testbench for the graphics memory organization block.
 * Assumes the memory model and the bound checker are compiled before it.
 */
`timescale 1ns/1ns
module gfx_mem_org_tb;
logic clk = 0, rst = 1, regSel = 0, regWrite = 0, regAck, hostValid = 0, apHit, pixValid = 0, pixOutValid;
logic cbReq = 0, cbOutValid, cbLineOk, modeIllegal, writeLocked;
logic [15:0] regAddr = 16'h0, pixData = 16'hA5C3;
logic [3:0] regByteEn = 4'h0, apertureUnits = 4'h2, vgaRegionSel = 4'h2, hostByteEn = 4'h6, apByteEn, pixByteEn;
logic [31:0] regWdata = 32'h0, regRdata, hostAddr = 32'h0, pixWdata;
logic [12:0] ramTopUnits = 13'h6;
logic [19:0] apWordOffset, pixWordOffset, cbWordOffset, cursorWordOffset, videoWordOffset;
logic [10:0] pixX = 11'h0;
logic [9:0] pixY = 10'h1DD, cbLine = 10'h7;
logic [6:0] cbLineLen = 7'h14;
logic [8:0] fbFetchSize;
int errTotal = 0, nCompared = 0;
always #50 clk = ~clk;
gfx_mem_org DUT (.clk, .rst, .regSel, .regWrite, .regAddr, .regByteEn, .regWdata, .regRdata, .regAck,
    .ramTopUnits, .apertureUnits, .vgaRegionSel, .hostValid, .hostAddr, .hostByteEn, .apHit, .apWordOffset,
    .apByteEn, .pixValid, .pixX, .pixY, .pixData, .pixOutValid, .pixWordOffset, .pixByteEn, .pixWdata, .cbReq,
    .cbLine, .cbLineLen, .cbOutValid, .cbWordOffset, .cbLineOk, .cursorWordOffset, .videoWordOffset,
    .fbFetchSize, .modeIllegal, .writeLocked);
gfx_mem_model MEM (.clk, .wrEn(pixOutValid), .wordOffset(pixWordOffset), .byteEn(pixByteEn), .wdata(pixWdata));
////////////////////////////////////////////////////////////////////////
task automatic tick();
    @(posedge clk);
    #10;
endtask
task automatic giveVerdict();
    $display("Compared %0d, mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
        errTotal++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task automatic rw(input logic w, input logic [15:0] a, input logic [3:0] be, input logic [31:0] d,
    output logic [31:0] q, output logic ack);
    regSel = 1;
    regWrite = w;
    regAddr = a;
    regByteEn = be;
    regWdata = d;
    tick();
    q = regRdata;
    ack = regAck;
    regSel = 0;
    tick();
endtask
task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
    logic [31:0] q;
    logic k;
    rw(1, a, be, d, q, k);
    chk(32'(k), 32'h1);
endtask
task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic k;
    rw(0, a, 4'hF, 32'h0, q, k);
    chk(32'(k), 32'h1);
    chk(q, exp);
endtask
////////////////////////////////////////////////////////////////////////
task automatic t_regs();
    logic [31:0] q;
    logic k;
    // Mid-run reset with the lock set must leave everything unlocked
    wr(16'h8300, 32'h1);
    rst = 1;
    tick();
    tick();
    rst = 0;
    tick();
    chk(32'(writeLocked), 32'h0);
    for (int a = 16'h8300; a <= 16'h8328; a += 4) rd(16'(a), 32'h0);
    for (int a = 16'h8310; a <= 16'h8328; a += 4) wr(16'(a), 32'h0030_0000 | 32'(a));
    wr(16'h831C, 32'hFFFF_FFFF);
    for (int a = 16'h8310; a <= 16'h8328; a += 4)
        rd(16'(a), (a == 16'h831C) ? 32'h0 : 32'h0030_0000 | 32'(a));
    chk(32'(cursorWordOffset), 32'hC20C6);
    chk(32'(videoWordOffset), 32'hC20C8);
    wr(16'h8310, 32'hAAAA_AAAA, 4'h2);
    rd(16'h8310, 32'h0030_AA10);
    rw(0, 16'h8400, 4'hF, 32'h0, q, k);
    chk(32'(k), 32'h0);
endtask
task automatic t_lock();
    wr(16'h8300, 32'h1);
    chk(32'(writeLocked), 32'h1);
    wr(16'h8310, 32'h0010_0040);
    rd(16'h8310, 32'h0030_AA10);
    rd(16'h8300, 32'h1);
    wr(16'h8300, 32'h0);
    wr(16'h8310, 32'h0010_0040);
    rd(16'h8310, 32'h0010_0040);
    wr(16'h8324, 32'h000C_0100);
    wr(16'h8328, 32'h0000_2880);
    chk(32'(fbFetchSize), 32'h80);
endtask
task automatic ap(input logic [31:0] a, input logic h, input logic [19:0] off);
    hostValid = 1;
    hostAddr = a;
    tick();
    chk(32'(apHit), 32'(h));
    chk(32'(apByteEn), h ? 32'h6 : 32'h0);
    if (h) chk(32'(apWordOffset), 32'(off));
    hostValid = 0;
    tick();
endtask
task automatic t_aperture();
    ap(32'h0030_0000, 1, 20'h0);
    ap(32'h003F_FFFC, 1, 20'h3FFFF);
    ap(32'h0040_0000, 0, 20'h0);
    ap(32'h002F_FFFC, 0, 20'h0);
    apertureUnits = 4'hF;
    ap(32'h006F_FFFC, 1, 20'hFFFFF);
    ap(32'h0070_0000, 0, 20'h0);
endtask
task automatic pix(input logic [21:0] base, input logic [3:0] m, input logic [10:0] x);
    logic b16, wide;
    logic [10:0] xb;
    logic [21:0] o, ofs;
    logic [3:0] be;
    logic [31:0] msk;
    b16 = m[2] && m[1:0] != 2'h3;
    wide = b16 || m[1:0] == 2'h3;
    xb = b16 ? {x[9:0], 1'b0} : x;
    ofs = wide ? {1'b0, pixY, xb} : {2'h0, pixY, xb[9:0]};
    // VGA refresh stays inside its 256 KB region
    o = m[3] ? (base | {4'h0, ofs[17:0]}) : base + ofs;
    be = b16 ? (x[0] ? 4'hC : 4'h3) : 4'h1 << x[1:0];
    msk = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    pixValid = 1;
    pixX = x;
    tick();
    chk(32'(pixByteEn), 32'(be));
    chk(32'(pixWordOffset), 32'(o[21:2]));
    pixValid = 0;
    tick();
    chk(MEM.peek(o[21:2]) & msk, (b16 ? {2{pixData}} : {4{pixData[7:0]}}) & msk);
endtask
task automatic t_pixel();
    for (int m = 0; m < 8; m++)
    begin
        wr(16'h8304, 32'(m));
        chk(32'(modeIllegal), 32'(m == 7));
        pix(22'h10_0040, 4'(m), 11'h12D);
        pix(22'h10_0040, 4'(m), 11'h3FE);
    end
    wr(16'h8304, 32'h8);
    pix(22'h08_0000, 4'h8, 11'h12D);
    // Host-converted text lands as a plain 8 bpp image
    wr(16'h8304, 32'h0);
    pix(22'h10_0040, 4'h0, 11'h008);
endtask
task automatic cb(input logic [3:0] m, input logic [6:0] len, input logic [19:0] w, input logic ok);
    wr(16'h8304, 32'(m));
    cbReq = 1;
    cbLineLen = len;
    tick();
    chk(32'(cbOutValid), 32'h1);
    chk(32'(cbWordOffset), 32'(w));
    chk(32'(cbLineOk), 32'(ok));
    cbReq = 0;
    tick();
endtask
task automatic t_comp();
    wr(16'h8314, 32'h0030_0000);
    cb(4'h1, 7'h14, 20'hC0700, 1);
    cb(4'h5, 7'h15, 20'hC0E00, 0);
    cb(4'h2, 7'h0, 20'hC0540, 1);
endtask
////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (4) @(posedge clk);
    #10;
    rst = 0;
    tick();
    chk(32'(writeLocked), 32'h0);
    t_regs();
    t_lock();
    t_aperture();
    t_pixel();
    t_comp();
    giveVerdict();
end
initial
begin
    repeat (20000) @(posedge clk);
    errTotal++;
    giveVerdict();
end
endmodule
